//--- hw/eia_pkg.sv
// eia_pkg: constants shared by the event interrupt aggregator
// assumes a single 125 MHz clock domain and a plain strobe register port
package eia_pkg;
  localparam int          EIA_AW            = 4;
  localparam int          EIA_DW            = 16;
  localparam int          EIA_NSRC          = 12;
  // ------------------------------------------------------------------
  // register offsets (word index on the plain port)
  // ------------------------------------------------------------------
  localparam logic [3:0]  EIA_OFF_ENABLE    = 4'h0;
  localparam logic [3:0]  EIA_OFF_FLAG      = 4'h1;
  localparam logic [3:0]  EIA_OFF_STATUS    = 4'h2;
  localparam logic [3:0]  EIA_OFF_FLAG_SET  = 4'h3;
  localparam logic [3:0]  EIA_OFF_FLAG_CLR  = 4'h4;
  localparam logic [3:0]  EIA_OFF_EN_SET    = 4'h5;
  localparam logic [3:0]  EIA_OFF_EN_CLR    = 4'h6;
  // ------------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------------
  localparam int          EIA_GIE_BIT       = 15;
  localparam int          EIA_PEND_BIT      = 15;
  localparam logic [15:0] EIA_SRC_MASK      = 16'h7BFF;
  localparam logic [15:0] EIA_ENABLE_RST    = 16'h0000;
  localparam logic [15:0] EIA_FLAG_RST      = 16'h0000;
  localparam logic [15:0] EIA_ZERO          = 16'h0000;

  typedef enum logic [1:0] {
    EIA_WR_PLAIN = 2'b00,
    EIA_WR_SET   = 2'b01,
    EIA_WR_CLR   = 2'b10
  } eia_wr_kind_t;

  // bit-level update used by both registers
  function automatic logic [15:0] eia_apply(input logic [15:0] cur,
                                            input logic [15:0] data,
                                            input eia_wr_kind_t kind);
    logic [15:0] res;
    res = cur;
    case (kind)
      EIA_WR_PLAIN: res = data;
      EIA_WR_SET:   res = cur | data;
      EIA_WR_CLR:   res = cur & ~data;
      default:      res = cur;
    endcase
    return res;
  endfunction
endpackage

//--- hw/eia_flag_bank.sv
// eia_flag_bank: sticky event flags with bit-set and bit-clear updates
// assumes event pulses come from logic on ref_clk
module eia_flag_bank
  import eia_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [15:0]  evt,
  input  wire logic         wr_en,
  input  wire eia_wr_kind_t wr_kind,
  input  wire logic [15:0]  wr_data,
  output logic      [15:0]  flag_r
);
  logic [15:0] flag_nxt;

  always_comb begin
    flag_nxt = flag_r;
    if (wr_en) begin
      flag_nxt = eia_apply(flag_r, wr_data, wr_kind);
    end
    // events win over a clear in the same cycle, even if disabled
    flag_nxt = (flag_nxt | evt) & EIA_SRC_MASK;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_r <= EIA_FLAG_RST;
    end else begin
      flag_r <= flag_nxt;
    end
  end
endmodule // eia_flag_bank

//--- hw/eia_irq_gate.sv
// eia_irq_gate: combines enabled flags and the global enable into the pin
// assumes enable and flag are registered on ref_clk
module eia_irq_gate
  import eia_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [15:0] enable_r,
  input  wire logic [15:0] flag_r,
  output logic             pending,
  output logic             irq_n_r
);
  // ------------------------------------------------------------------
  // combine
  // ------------------------------------------------------------------
  // pin follows the condition one clock later, so dropping the global enable releases it
  // on the next edge and raising it again with flags set gives a new falling edge
  assign pending = enable_r[EIA_GIE_BIT] & (|(enable_r & flag_r & EIA_SRC_MASK));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= ~pending;
    end
  end
endmodule // eia_irq_gate

//--- hw/eia_top.sv
// eia_top: event interrupt aggregator with plain strobe register port
// assumes the host port logic issues one-cycle strobes on ref_clk
// What this block does
// - all sources share one active-low interrupt pin.
// - one enable bit and one flag bit per source, in two registers.
// - a flag sets on its event whether or not it is enabled.
// - the pin goes low and pending sets only for an enabled flag with global enable set.
// - status bit 15 mirrors the combined interrupt condition for polling.
// - the pin stays low until contributing flags are cleared or disabled.
// - clearing global enable releases the pin high on the clock after the enable register changes.
// - setting global enable with enabled flags set gives a new falling edge.
// - flags clear only by bit-clear operations touching just the addressed bits.
module eia_top
  import eia_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [15:0]       evt,
  input  wire logic [EIA_AW-1:0] addr,
  input  wire logic [15:0]       wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [15:0]       rdata_r,
  output logic                   irq_n
);
  logic [15:0]  enable_r;
  logic [15:0]  enable_nxt;
  logic [15:0]  flag_r;
  logic         pending;
  logic         flag_wr;
  eia_wr_kind_t flag_kind;
  logic [15:0]  rd_nxt;

  // ------------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------------
  // plain writes to the flag register are ignored: only set/clear aliases
  // may touch flags, so an event landing mid-write is never overwritten
  always_comb begin
    flag_wr   = 1'b0;
    flag_kind = EIA_WR_CLR;
    if (wr_stb && addr == EIA_OFF_FLAG_CLR) begin
      flag_wr   = 1'b1;
      flag_kind = EIA_WR_CLR;
    end else if (wr_stb && addr == EIA_OFF_FLAG_SET) begin
      flag_wr   = 1'b1;
      flag_kind = EIA_WR_SET;
    end
  end

  always_comb begin
    enable_nxt = enable_r;
    if (wr_stb && addr == EIA_OFF_ENABLE) begin
      enable_nxt = eia_apply(enable_r, wdata, EIA_WR_PLAIN);
    end else if (wr_stb && addr == EIA_OFF_EN_SET) begin
      enable_nxt = eia_apply(enable_r, wdata, EIA_WR_SET);
    end else if (wr_stb && addr == EIA_OFF_EN_CLR) begin
      enable_nxt = eia_apply(enable_r, wdata, EIA_WR_CLR);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      enable_r <= EIA_ENABLE_RST;
    end else begin
      enable_r <= enable_nxt & (EIA_SRC_MASK | (16'h0001 << EIA_GIE_BIT));
    end
  end

  // ------------------------------------------------------------------
  // flags and interrupt
  // ------------------------------------------------------------------
  eia_flag_bank u_flags (
    .ref_clk (ref_clk),
    .rst     (rst),
    .evt     (evt),
    .wr_en   (flag_wr),
    .wr_kind (flag_kind),
    .wr_data (wdata),
    .flag_r  (flag_r)
  );

  eia_irq_gate u_gate (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .enable_r (enable_r),
    .flag_r   (flag_r),
    .pending  (pending),
    .irq_n_r  (irq_n)
  );

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  always_comb begin
    rd_nxt = EIA_ZERO;
    if (addr == EIA_OFF_ENABLE || addr == EIA_OFF_EN_SET || addr == EIA_OFF_EN_CLR) begin
      rd_nxt = enable_r;
    end else if (addr == EIA_OFF_FLAG || addr == EIA_OFF_FLAG_SET
                 || addr == EIA_OFF_FLAG_CLR) begin
      rd_nxt = flag_r;
    end else if (addr == EIA_OFF_STATUS) begin
      rd_nxt = EIA_ZERO;
      rd_nxt[EIA_PEND_BIT] = pending;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_r <= EIA_ZERO;
    end else if (rd_stb) begin
      rdata_r <= rd_nxt;
    end else begin
      rdata_r <= EIA_ZERO;
    end
  end
endmodule // eia_top

//--- sim/eia_top_props.sv
// eia_top_props: port-level checks of eia_top
// assumes one clock domain and a bench that drives plain strobes
module eia_top_props
  import eia_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic [15:0]       evt,
  input wire logic [EIA_AW-1:0] addr,
  input wire logic [15:0]       wdata,
  input wire logic              wr_stb,
  input wire logic              rd_stb,
  input wire logic [15:0]       rdata_r,
  input wire logic              irq_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence gie_drop;
    wr_stb && ((addr == EIA_OFF_ENABLE && !wdata[15]) || (addr == EIA_OFF_EN_CLR && wdata[15]));
  endsequence
  rd_idle_a: assert property (!$past(rd_stb) |-> rdata_r == 16'h0000)
    else $error("read data outside its slot");
  gie_off_a: assert property (gie_drop |-> ##2 irq_n)
    else $error("pin low after global enable cleared");
  fall_cause_a: assert property ($fell(irq_n) |-> $past(wr_stb, 2) ||
    ($past(evt & EIA_SRC_MASK, 2) != 16'h0000)) else $error("pin fell without cause");
  rise_cause_a: assert property ($rose(irq_n) |-> $past(wr_stb, 2))
    else $error("pin released without a write");
  irq_hold_a: assert property (!irq_n && !$past(wr_stb) |=> !irq_n)
    else $error("pin released early");
  pend_poll_a: assert property (rd_stb && addr == EIA_OFF_STATUS |=> rdata_r[15] == !irq_n)
    else $error("pending bit differs from pin");
  resv_zero_a: assert property (rd_stb && (addr == EIA_OFF_FLAG || addr == EIA_OFF_FLAG_CLR)
    |=> (rdata_r & ~EIA_SRC_MASK) == 16'h0000) else $error("reserved flag bit set");
  unmapped_rd_a: assert property (rd_stb && addr > 4'h6 |=> rdata_r == 16'h0000)
    else $error("unmapped read not zero");
endmodule // eia_top_props

bind eia_top eia_top_props u_props (.ref_clk, .rst, .evt, .addr, .wdata, .wr_stb, .rd_stb,
  .rdata_r, .irq_n);

//--- sim/eia_host_model.sv
// eia_host_model: host that reacts to falling edges of the interrupt pin
// assumes irq_n is a registered level on ref_clk
module eia_host_model (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       irq_n,
  output logic      [7:0] fall_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irq_q;
  // an edge-sensitive host sees a pin held low only once
  always_ff @(posedge ref_clk) begin
    irq_q <= irq_n;
    if (rst) fall_cnt <= 8'h00;
    else if (irq_q && !irq_n) fall_cnt <= fall_cnt + 8'h01;
  end
endmodule // eia_host_model

//--- sim/eia_tb_top.sv
// eia_tb_top: directed bench for eia_top
// assumes the checker and host model are compiled before it
module eia_tb_top
  import eia_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              ref_clk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, irq_n;
  logic [15:0]       evt = 16'h0000, wdata = 16'h0000, rdata_r;
  logic [EIA_AW-1:0] addr = 4'h0;
  logic [7:0]        fall_cnt;
  int                n_fail = 0, comparisons = 0;
  eia_top u_dut (.ref_clk, .rst, .evt, .addr, .wdata, .wr_stb, .rd_stb, .rdata_r, .irq_n);
  eia_host_model u_host (.ref_clk, .rst, .irq_n, .fall_cnt);
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 chk(rdata_r, exp);
  endtask
  // the pin is registered behind the registers, so it lags a write by two edges
  task automatic pin(input logic exp);
    repeat (2) @(posedge ref_clk);
    #1 chk({15'h0000, irq_n}, {15'h0000, exp});
  endtask
  task automatic t_reset();
    rd(4'h0, 16'h0000);
    wr(4'h1, 16'hFFFF);
    wr(4'h2, 16'hFFFF);
    rd(4'h1, 16'h0000);
    rd(4'h2, 16'h0000);
    rd(4'hF, 16'h0000);
    pin(1'b1);
  endtask
  task automatic t_sticky();
    @(posedge ref_clk);
    evt <= 16'hFFFF;
    @(posedge ref_clk);
    evt <= 16'h0000;
    rd(4'h1, 16'h7BFF);
    wr(4'h0, 16'h0001);
    pin(1'b1);
    wr(4'h5, 16'h8000);
    pin(1'b0);
    rd(4'h2, 16'h8000);
    chk({8'h00, fall_cnt}, 16'h0001);
  endtask
  task automatic t_service();
    wr(4'h4, 16'h7BFE);
    pin(1'b0);
    rd(4'h1, 16'h0001);
    wr(4'h6, 16'h8000);
    pin(1'b1);
    wr(4'h5, 16'h8000);
    pin(1'b0);
    chk({8'h00, fall_cnt}, 16'h0002);
  endtask
  task automatic t_race();
    @(posedge ref_clk);
    evt <= 16'h0001;
    wr_stb <= 1'b1;
    addr <= EIA_OFF_FLAG_CLR;
    wdata <= 16'h0001;
    @(posedge ref_clk);
    evt <= 16'h0000;
    wr_stb <= 1'b0;
    rd(4'h1, 16'h0001);
    wr(4'h4, 16'h0001);
    pin(1'b1);
    rd(4'h2, 16'h0000);
    // set alias: bits 15 and 10 are not sources and must not stick
    wr(4'h3, 16'h8404);
    rd(4'h1, 16'h0004);
    pin(1'b1);
    wr(4'h5, 16'h0004);
    pin(1'b0);
    rd(4'h1, 16'h0004);
    wr(4'h6, 16'h0004);
    pin(1'b1);
    chk({8'h00, fall_cnt}, 16'h0003);
  endtask
  task automatic complete_run();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_sticky();
    t_service();
    t_race();
    complete_run();
  end
endmodule // eia_tb_top
